//--- hw/mfm_pkg.sv
// Package for the multichannel frequency meter: constants and enumerations
package mfm_pkg;
  localparam int MFM_CHANNELS = 5;
  localparam int MFM_CLK_HZ = 10000000;
  localparam int MFM_FMAX_HZ = 200000;
  localparam int MFM_CNT_W = 18;
  localparam int MFM_FREQ_W = 24;
  // Gate times in milliseconds, then in clock cycles
  localparam int MFM_GATE_1S_MS = 1000;
  localparam int MFM_GATE_100MS_MS = 100;
  localparam int MFM_GATE_10MS_MS = 10;
  localparam int MFM_GATE_1S_CYC = MFM_CLK_HZ / 1000 * MFM_GATE_1S_MS;
  localparam int MFM_GATE_100MS_CYC = MFM_CLK_HZ / 1000 * MFM_GATE_100MS_MS;
  localparam int MFM_GATE_10MS_CYC = MFM_CLK_HZ / 1000 * MFM_GATE_10MS_MS;
  // Multipliers from count to hertz
  localparam int MFM_MUL_1S = 1;
  localparam int MFM_MUL_100MS = 10;
  localparam int MFM_MUL_10MS = 100;
  // Sample period in microseconds, 1 us to 0.16 s
  localparam int MFM_SAMPLE_PERIOD_SETTING_MIN_US = 1;
  localparam int MFM_SAMPLE_PERIOD_SETTING_MAX_US = 160000;
  localparam int MFM_SAMPLE_PERIOD_SETTING_W = 18;
  localparam int MFM_CYC_PER_US = MFM_CLK_HZ / 1000000;
  localparam logic [MFM_SAMPLE_PERIOD_SETTING_W-1:0] MFM_SAMPLE_PERIOD_SETTING_RESET = 18'h00001;
  // Auto gate: shorter gate once counts exceed this
  localparam logic [MFM_CNT_W-1:0] MFM_AUTO_HIGH = 18'h02710;
  localparam logic [MFM_CNT_W-1:0] MFM_AUTO_LOW = 18'h00064;

  typedef enum logic [1:0] {
    MFM_GATE_AUTO = 2'h0,
    MFM_GATE_1S = 2'h1,
    MFM_GATE_100MS = 2'h2,
    MFM_GATE_10MS = 2'h3
  } mfm_gate_type;

  typedef enum logic [2:0] {
    MFM_TRIG_OFF = 3'h0,
    MFM_TRIG_SINGLE = 3'h1,
    MFM_TRIG_EXTERNAL = 3'h2,
    MFM_TRIG_SYSTEM = 3'h3,
    MFM_TRIG_INTERNAL = 3'h4
  } mfm_trig_type;

  typedef enum logic [1:0] {
    MFM_ST_IDLE = 2'b00,
    MFM_ST_DELAY = 2'b01,
    MFM_ST_GATE = 2'b11
  } mfm_state_type;
endpackage

//--- hw/mfm_edge_counter.sv
// One channel's input synchroniser and selected-edge counter
`timescale 1ns/1ps
module mfm_edge_counter #(
  parameter int CNT_W = 18
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Input and controls
  input wire logic sig_a,
  input wire logic count_falling_edges,
  input wire logic clear,
  input wire logic enable,
  // Count
  output logic [CNT_W-1:0] count
);
  logic sync1_q, sync2_q, prev_q;
  logic [CNT_W-1:0] count_q;
  wire rise = sync2_q & ~prev_q;
  wire fall = ~sync2_q & prev_q;
  wire hit = count_falling_edges ? fall : rise;
  wire sat = &count_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= sig_a;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || clear) begin
      count_q <= '0;
    end else if (enable && hit && !sat) begin
      count_q <= count_q + 1'b1;
    end
  end

  assign count = count_q;
endmodule // mfm_edge_counter

//--- hw/mfm_meter.sv
// Five-channel frequency meter top
`timescale 1ns/1ps
//
// Contract
// - Frequency of a channel's A input is measured from just above 1 Hz up to 200 kHz.
// - All five channels, 0 to 4, measure at the same time using only their A inputs.
// - An enabled channel raises a measurement-complete interrupt when its measurement ends; commands enable and disable it.
// - Each channel counts rising or falling A edges as its polarity setting selects.
// - Gate time is 1 s, 0.1 s, 0.01 s or automatic, automatic by default.
// - Sample period is programmable from 1 us to 0.16 s and is 1 us after power-on.
// - External, system, single, internal and off trigger modes exist; off at power-on, single when no mode given.
// - With a 0.1 s gate the result resolves 10 Hz and covers 10 Hz to 200 kHz.
// - A read request for channel 0 to 4 returns its frequency; a transfer request also moves it to the host.
// - Channel-function selection is ignored for frequency measurement; the gate setting configures it.
module mfm_meter #(
  parameter int CHANNELS = mfm_pkg::MFM_CHANNELS,
  parameter int GATE_1S_CYC = mfm_pkg::MFM_GATE_1S_CYC,
  parameter int GATE_100MS_CYC = mfm_pkg::MFM_GATE_100MS_CYC,
  parameter int GATE_10MS_CYC = mfm_pkg::MFM_GATE_10MS_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Signal inputs, A per channel
  input wire logic [CHANNELS-1:0] sig_a,
  // Per-channel edge polarity
  input wire logic [CHANNELS-1:0] count_falling_edges,
  // Gate time
  input wire logic gate_set,
  input wire mfm_pkg::mfm_gate_type gate_sel,
  // Sample period in microseconds
  input wire logic sample_period_set,
  input wire logic [mfm_pkg::MFM_SAMPLE_PERIOD_SETTING_W-1:0] sample_period_setting,
  // Trigger control
  input wire logic trig_mode_set,
  input wire logic trig_mode_given,
  input wire mfm_pkg::mfm_trig_type trig_mode,
  input wire logic external_trigger,
  input wire logic system_trigger,
  // Channel function select, accepted and ignored
  input wire logic channel_function_select,
  // Interrupt enable commands
  input wire logic [CHANNELS-1:0] intr_enable_cmd,
  input wire logic [CHANNELS-1:0] intr_disable_cmd,
  // Read and transfer requests
  input wire logic channel_read_request,
  input wire logic reading_transfer_request,
  input wire logic [2:0] read_channel,
  // Results
  output logic [mfm_pkg::MFM_FREQ_W-1:0] read_data,
  output logic read_valid,
  output logic xfer_valid,
  output logic read_error,
  output logic [CHANNELS-1:0] meas_done_irq,
  output logic [CHANNELS-1:0] reading_ready,
  output logic busy
);
  import mfm_pkg::*;

  localparam int GCW = 24;
  localparam int SCW = 22;

  mfm_gate_type gate_q;
  mfm_trig_type trig_q;
  mfm_state_type state_q, state_d;
  mfm_gate_type run_gate_q;
  logic [MFM_SAMPLE_PERIOD_SETTING_W-1:0] sample_period_setting_q;
  logic [GCW-1:0] gate_cnt_q;
  logic [SCW-1:0] delay_cnt_q;
  logic [CHANNELS-1:0] ie_q, irq_q, ready_q;
  logic [MFM_FREQ_W-1:0] freq_q [CHANNELS];
  logic [MFM_FREQ_W-1:0] read_data_q;
  logic read_valid_q, xfer_valid_q, read_error_q;
  logic [MFM_CNT_W-1:0] cnt [CHANNELS];
  logic ext_s1_q, ext_s2_q, ext_p_q, sys_s1_q, sys_s2_q, sys_p_q;
  logic auto_up_q, auto_down_q;
  logic single_pend_q;

  // External triggers are pins, so synchronise them
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_p_q <= 1'b0;
      sys_s1_q <= 1'b0;
      sys_s2_q <= 1'b0;
      sys_p_q <= 1'b0;
    end else begin
      ext_s1_q <= external_trigger;
      ext_s2_q <= ext_s1_q;
      ext_p_q <= ext_s2_q;
      sys_s1_q <= system_trigger;
      sys_s2_q <= sys_s1_q;
      sys_p_q <= sys_s2_q;
    end
  end

  wire ext_edge = ext_s2_q & ~ext_p_q;
  wire sys_edge = sys_s2_q & ~sys_p_q;

  // Effective gate at start; auto steps by last result
  wire mfm_gate_type auto_gate = auto_up_q ? MFM_GATE_10MS : (auto_down_q ? MFM_GATE_1S : MFM_GATE_100MS);
  wire mfm_gate_type eff_gate = (gate_q == MFM_GATE_AUTO) ? auto_gate : gate_q;
  wire [GCW-1:0] gate_len = (run_gate_q == MFM_GATE_1S) ? GCW'(GATE_1S_CYC) :
                            (run_gate_q == MFM_GATE_10MS) ? GCW'(GATE_10MS_CYC) :
                            GCW'(GATE_100MS_CYC);
  wire [7:0] gate_mul = (run_gate_q == MFM_GATE_1S) ? 8'(MFM_MUL_1S) :
                        (run_gate_q == MFM_GATE_10MS) ? 8'(MFM_MUL_10MS) :
                        8'(MFM_MUL_100MS);
  wire [SCW-1:0] delay_len = SCW'(sample_period_setting_q) * SCW'(MFM_CYC_PER_US);

  wire start_req = (state_q == MFM_ST_IDLE) && (
    (trig_q == MFM_TRIG_SINGLE && single_pend_q) ||
    (trig_q == MFM_TRIG_EXTERNAL && ext_edge) ||
    (trig_q == MFM_TRIG_SYSTEM && sys_edge) ||
    (trig_q == MFM_TRIG_INTERNAL));
  wire gate_end = (state_q == MFM_ST_GATE) && (gate_cnt_q == gate_len - 1'b1);
  wire delay_end = (state_q == MFM_ST_DELAY) && (delay_cnt_q >= delay_len - 1'b1);

  always_comb begin
    state_d = state_q;
    case (state_q)
      MFM_ST_IDLE: if (start_req) state_d = MFM_ST_DELAY;
      MFM_ST_DELAY: if (delay_end) state_d = MFM_ST_GATE;
      MFM_ST_GATE: if (gate_end) state_d = MFM_ST_IDLE;
      default: state_d = MFM_ST_IDLE;
    endcase
  end

  // Settings; function select has no effect here
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gate_q <= MFM_GATE_AUTO;
      sample_period_setting_q <= MFM_SAMPLE_PERIOD_SETTING_RESET;
      trig_q <= MFM_TRIG_OFF;
      single_pend_q <= 1'b0;
    end else begin
      if (gate_set) gate_q <= gate_sel;
      if (sample_period_set && sample_period_setting >= MFM_SAMPLE_PERIOD_SETTING_W'(MFM_SAMPLE_PERIOD_SETTING_MIN_US) &&
          sample_period_setting <= MFM_SAMPLE_PERIOD_SETTING_W'(MFM_SAMPLE_PERIOD_SETTING_MAX_US)) sample_period_setting_q <= sample_period_setting;
      if (trig_mode_set) begin
        trig_q <= trig_mode_given ? trig_mode : MFM_TRIG_SINGLE;
        single_pend_q <= !trig_mode_given || trig_mode == MFM_TRIG_SINGLE;
      end else if (start_req) begin
        single_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= MFM_ST_IDLE;
      gate_cnt_q <= '0;
      delay_cnt_q <= '0;
      run_gate_q <= MFM_GATE_100MS;
    end else begin
      state_q <= state_d;
      gate_cnt_q <= (state_q == MFM_ST_GATE && !gate_end) ? gate_cnt_q + 1'b1 : '0;
      delay_cnt_q <= (state_q == MFM_ST_DELAY && !delay_end) ? delay_cnt_q + 1'b1 : '0;
      if (start_req) run_gate_q <= eff_gate;
    end
  end

  // All channels share one gate so they measure together
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      mfm_edge_counter #(.CNT_W(MFM_CNT_W)) u_cnt (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .sig_a(sig_a[g]),
        .count_falling_edges(count_falling_edges[g]),
        .clear(state_q == MFM_ST_DELAY),
        .enable(state_q == MFM_ST_GATE),
        .count(cnt[g])
      );

      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          freq_q[g] <= '0;
          ready_q[g] <= 1'b0;
        end else if (gate_end) begin
          freq_q[g] <= MFM_FREQ_W'(cnt[g] * gate_mul);
          ready_q[g] <= 1'b1;
        end
      end

      // Completion wins over a disable in the same cycle
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          ie_q[g] <= 1'b0;
          irq_q[g] <= 1'b0;
        end else begin
          if (intr_enable_cmd[g]) ie_q[g] <= 1'b1;
          else if (intr_disable_cmd[g]) ie_q[g] <= 1'b0;
          if (gate_end && ie_q[g]) irq_q[g] <= 1'b1;
          else if (intr_disable_cmd[g] || (channel_read_request && read_channel == 3'(g))) irq_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Auto gate tracks channel 0 range
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      auto_up_q <= 1'b0;
      auto_down_q <= 1'b0;
    end else if (gate_end) begin
      auto_up_q <= cnt[0] > MFM_AUTO_HIGH;
      auto_down_q <= cnt[0] < MFM_AUTO_LOW && run_gate_q != MFM_GATE_10MS;
    end
  end

  wire rd_any = channel_read_request | reading_transfer_request;
  wire rd_ok = read_channel < 3'(CHANNELS);
  wire [MFM_FREQ_W-1:0] rd_mux = rd_ok ? freq_q[read_channel] : '0;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      read_data_q <= '0;
      read_valid_q <= 1'b0;
      xfer_valid_q <= 1'b0;
      read_error_q <= 1'b0;
    end else begin
      if (rd_any) read_data_q <= rd_mux;
      read_valid_q <= channel_read_request & rd_ok;
      xfer_valid_q <= reading_transfer_request & rd_ok;
      read_error_q <= rd_any & ~rd_ok;
    end
  end

  logic busy_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) busy_q <= 1'b0;
    else busy_q <= state_d != MFM_ST_IDLE;
  end

  assign read_data = read_data_q;
  assign read_valid = read_valid_q;
  assign xfer_valid = xfer_valid_q;
  assign read_error = read_error_q;
  assign meas_done_irq = irq_q;
  assign reading_ready = ready_q;
  assign busy = busy_q;
endmodule // mfm_meter

//--- sim/mfm_signal_source.sv
// Square-wave field signal for one input channel
`timescale 1ns/1ps
module mfm_signal_source #(
  parameter int HALF = 2
) (
  // Clock the pattern is timed from
  input wire logic clk_sys,
  // Generated level
  output logic sig
);
  int cnt = 0;
  initial sig = 1'b0;
  // Offset from the edge, so phase to the sampler is arbitrary
  always @(posedge clk_sys) begin
    #13;
    cnt = (cnt + 1) % HALF;
    if (cnt == 0) sig = ~sig;
  end
endmodule // mfm_signal_source

//--- sim/mfm_meter_checker.sv
// Port checker for the frequency meter, bound to its top
`timescale 1ns/1ps
module mfm_meter_checker #(
  parameter int CHANNELS = 5
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Requests
  input wire logic channel_read_request,
  input wire logic reading_transfer_request,
  input wire logic [2:0] read_channel,
  input wire logic [CHANNELS-1:0] intr_enable_cmd,
  input wire logic [CHANNELS-1:0] intr_disable_cmd,
  // Results
  input wire logic [mfm_pkg::MFM_FREQ_W-1:0] read_data,
  input wire logic read_valid,
  input wire logic xfer_valid,
  input wire logic read_error,
  input wire logic [CHANNELS-1:0] meas_done_irq,
  input wire logic [CHANNELS-1:0] reading_ready,
  input wire logic busy
);
  import mfm_pkg::*;
  logic [CHANNELS-1:0] en_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Enable state as the commands leave it, enable winning
  always_ff @(posedge clk_sys) begin
    if (sys_rst) en_q <= '0;
    else en_q <= intr_enable_cmd | (en_q & ~intr_disable_cmd);
  end
  sequence s_busy_run; busy [*8]; endsequence
  sequence s_idle; !busy [*8]; endsequence
  sequence s_rd_good; channel_read_request && read_channel <= 3'h4; endsequence
  property p_read_ans; s_rd_good |=> read_valid && !read_error; endproperty
  a_read_ans: assert property (p_read_ans) else $error("read not answered");
  property p_read_err; channel_read_request && read_channel > 3'h4 |=> read_error && !read_valid; endproperty
  a_read_err: assert property (p_read_err) else $error("bad channel not refused");
  property p_xfer_ans; reading_transfer_request && read_channel <= 3'h4 |=> xfer_valid; endproperty
  a_xfer_ans: assert property (p_xfer_ans) else $error("transfer not answered");
  property p_data_hold; !channel_read_request && !reading_transfer_request |=> $stable(read_data); endproperty
  a_data_hold: assert property (p_data_hold) else $error("read data moved");
  property p_irq_gate; ((meas_done_irq & ~$past(meas_done_irq)) & ~$past(en_q)) == '0; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq on disabled channel");
  property p_irq_clear; channel_read_request && read_channel == 3'h0 && !busy |=> !meas_done_irq[0]; endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared by read");
  property p_busy_run; $rose(busy) |-> s_busy_run; endproperty
  a_busy_run: assert property (p_busy_run) else $error("measurement too short");
  property p_rst_idle; $fell(sys_rst) |-> meas_done_irq == '0 && reading_ready == '0 ##0 s_idle; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("activity after reset");
endmodule // mfm_meter_checker

bind mfm_meter mfm_meter_checker #(.CHANNELS(CHANNELS)) i_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .channel_read_request(channel_read_request),
  .reading_transfer_request(reading_transfer_request), .read_channel(read_channel),
  .intr_enable_cmd(intr_enable_cmd), .intr_disable_cmd(intr_disable_cmd), .read_data(read_data),
  .read_valid(read_valid), .xfer_valid(xfer_valid), .read_error(read_error),
  .meas_done_irq(meas_done_irq), .reading_ready(reading_ready), .busy(busy));

//--- sim/mfm_meter_tb.sv
// Self-checking bench for the frequency meter
`timescale 1ns/1ps
module mfm_meter_tb;
  import mfm_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] sig_a;
  logic [4:0] count_falling_edges = 5'h00;
  logic gate_set = 1'b0;
  mfm_gate_type gate_sel = MFM_GATE_AUTO;
  logic sample_period_set = 1'b0;
  logic [17:0] sample_period_setting = 18'h00001;
  logic trig_mode_set = 1'b0;
  logic trig_mode_given = 1'b0;
  mfm_trig_type trig_mode = MFM_TRIG_OFF;
  logic external_trigger = 1'b0;
  logic system_trigger = 1'b0;
  logic channel_function_select = 1'b1;
  logic [4:0] intr_enable_cmd = 5'h00;
  logic [4:0] intr_disable_cmd = 5'h00;
  logic channel_read_request = 1'b0;
  logic reading_transfer_request = 1'b0;
  logic [2:0] read_channel = 3'h0;
  logic [23:0] read_data;
  logic read_valid;
  logic xfer_valid;
  logic read_error;
  logic busy;
  logic [4:0] meas_done_irq;
  logic [4:0] reading_ready;
  int n_fail = 0;
  int n_checks = 0;
  int tol = 0;
  logic [23:0] exp_q[$];
  logic [31:0] seed = 32'h00011C12;
  always #50 clk_sys = ~clk_sys;
  // Short gates keep the run brief
  mfm_meter #(.GATE_1S_CYC(1000), .GATE_100MS_CYC(100), .GATE_10MS_CYC(10)) i_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sig_a(sig_a), .count_falling_edges(count_falling_edges),
    .gate_set(gate_set), .gate_sel(gate_sel), .sample_period_set(sample_period_set),
    .sample_period_setting(sample_period_setting), .trig_mode_set(trig_mode_set),
    .trig_mode_given(trig_mode_given), .trig_mode(trig_mode), .external_trigger(external_trigger),
    .system_trigger(system_trigger), .channel_function_select(channel_function_select),
    .intr_enable_cmd(intr_enable_cmd), .intr_disable_cmd(intr_disable_cmd),
    .channel_read_request(channel_read_request), .reading_transfer_request(reading_transfer_request),
    .read_channel(read_channel), .read_data(read_data), .read_valid(read_valid), .xfer_valid(xfer_valid),
    .read_error(read_error), .meas_done_irq(meas_done_irq), .reading_ready(reading_ready), .busy(busy));
  for (genvar k = 0; k < 5; k++) begin : g_src
    mfm_signal_source #(.HALF(2 + 3 * k)) i_src (.clk_sys(clk_sys), .sig(sig_a[k]));
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Edge phase is free, so a count may be off by one
  task automatic ck(input string n, input logic [23:0] e, input logic [23:0] s, input int t);
    logic [23:0] d;
    d = (s > e) ? s - e : e - s;
    n_checks++;
    if ((d <= t) !== 1'b1) begin
      n_fail++;
      $display("[ERR] %s expected %0d seen %0d", n, e, s);
    end
  endtask
  task automatic rd(input logic [2:0] ch, input logic x, input logic [23:0] e);
    @(posedge clk_sys);
    channel_read_request <= !x;
    reading_transfer_request <= x;
    read_channel <= ch;
    exp_q.push_back(e);
    @(posedge clk_sys);
    channel_read_request <= 1'b0;
    reading_transfer_request <= 1'b0;
  endtask
  task automatic trig(input mfm_trig_type m, input logic g);
    @(posedge clk_sys);
    trig_mode_set <= 1'b1;
    trig_mode_given <= g;
    trig_mode <= m;
    @(posedge clk_sys);
    trig_mode_set <= 1'b0;
  endtask
  task automatic wirq();
    int i;
    for (i = 0; i < 20000; i++) begin
      @(negedge clk_sys);
      if (meas_done_irq[0] === 1'b1) break;
    end
    if (i == 20000) begin
      n_fail++;
      conclude();
    end
  endtask
  always @(negedge clk_sys) begin
    if (read_valid === 1'b1 || xfer_valid === 1'b1) begin
      if (exp_q.size() == 0) ck("read_valid", 24'h0, 24'h1, 0);
      else ck("read_data", exp_q.pop_front(), read_data, tol);
    end
  end
  initial begin
    int g;
    int c;
    int cyc;
    int mul;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (19) @(posedge clk_sys);
    @(negedge clk_sys);
    ck("busy", 24'h0, {23'h0, busy}, 0);
    ck("reading_ready", 24'h0, {19'h0, reading_ready}, 0);
    @(posedge clk_sys);
    intr_enable_cmd <= 5'h1F;
    @(posedge clk_sys);
    intr_enable_cmd <= 5'h00;
    // Pass 0 leaves the gate at its automatic default
    for (g = 0; g < 4; g++) begin
      seed = xs(seed);
      cyc = (g == 1) ? 1000 : (g == 3) ? 10 : 100;
      mul = (g == 1) ? 1 : (g == 3) ? 100 : 10;
      tol = mul;
      @(posedge clk_sys);
      gate_set <= (g != 0);
      gate_sel <= mfm_gate_type'(g);
      sample_period_set <= 1'b1;
      sample_period_setting <= 18'(seed[2:0]) + 18'h00001;
      count_falling_edges <= seed[12:8];
      intr_disable_cmd <= (g == 3) ? 5'h1E : 5'h00;
      @(posedge clk_sys);
      gate_set <= 1'b0;
      sample_period_set <= 1'b0;
      intr_disable_cmd <= 5'h00;
      trig(MFM_TRIG_SINGLE, g[0]);
      wirq();
      repeat (2) @(negedge clk_sys);
      ck("meas_done_irq", (g == 3) ? 24'h1 : 24'h1F, {19'h0, meas_done_irq}, 0);
      ck("reading_ready", 24'h1F, {19'h0, reading_ready}, 0);
      for (c = 0; c < 5; c++) rd(3'(c), 1'b0, 24'(cyc * mul / (4 + 6 * c)));
      rd(3'h0, 1'b1, 24'(cyc * mul / 4));
      @(negedge clk_sys);
      ck("meas_done_irq", 24'h0, {19'h0, meas_done_irq}, 0);
    end
    @(posedge clk_sys);
    channel_read_request <= 1'b1;
    read_channel <= 3'h5;
    @(posedge clk_sys);
    channel_read_request <= 1'b0;
    @(negedge clk_sys);
    ck("read_error", 24'h1, {23'h0, read_error}, 0);
    // External, system, then internal, which must rerun by itself
    for (g = 2; g < 5; g++) begin
      trig(mfm_trig_type'(g), 1'b1);
      external_trigger <= 1'b1;
      system_trigger <= 1'b1;
      repeat ((g == 4) ? 2 : 1) begin
        wirq();
        rd(3'h0, 1'b0, 24'h0000FA);
      end
      external_trigger <= 1'b0;
      system_trigger <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    conclude();
  end
endmodule // mfm_meter_tb
